// ### inc/lnpc_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures
 * for the link node identity, PHY access and cycle timer registers.
 * Assumes a 250 MHz core clock and a byte address bus of 8 bits.
 */
`ifndef LNPC_REGS_SVH
`define LNPC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LNPC_NODE_ID_OFF 8'hE8
`define LNPC_PHY_CTL_OFF 8'hEC
`define LNPC_CYC_TIME_OFF 8'hF0
`define LNPC_LINK_CTL_OFF 8'hF4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LNPC_SEG_FLD 15:6
`define LNPC_NODE_FLD 5:0
`define LNPC_RDREQ_BIT 15
`define LNPC_WRREQ_BIT 14
`define LNPC_TADDR_FLD 11:8
`define LNPC_WVAL_FLD 7:0
`define LNPC_SECS_FLD 31:25
`define LNPC_CYC_FLD 24:12
`define LNPC_OFF_FLD 11:0
`define LNPC_EXTSEL_BIT 22
`define LNPC_MASTER_BIT 21
`define LNPC_TEN_BIT 20

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define LNPC_SEG_RST 10'h3FF
`define LNPC_OFF_LAST 12'hBFF
`define LNPC_CYC_LAST 13'h1F3F
`define LNPC_NODE_UNSET 6'h3F

// ----------------------------------------------------------------
// Timing: core clock and offset tick rate, both in kHz
// ----------------------------------------------------------------
`define LNPC_CLK_KHZ 19'h3D090
`define LNPC_TICK_KHZ 19'h06000

`endif

// ### inc/lnpc_pkg.sv
/*
 * Types shared by the link node, PHY access and cycle timer block.
 * Assumes the constants header is compiled alongside.
 */
package lnpc_pkg;
    typedef logic [31:0] lnpc_word_t;
    typedef logic [7:0] lnpc_addr_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic ext_filt;
        logic [18:0] acc;
        logic valid;
        logic root;
        logic pwr_ok;
        logic [9:0] seg;
        logic [5:0] node;
        logic done;
        logic [3:0] raddr;
        logic [7:0] rval;
        logic rdreq;
        logic wrreq;
        logic [3:0] taddr;
        logic [7:0] wval;
        logic [6:0] secs;
        logic [12:0] cyc;
        logic [11:0] off;
        logic extsel;
        logic master;
        logic ten;
        logic [31:0] rdata;
        logic tx_v;
        logic [31:0] tx_data;
    } lnpc_state_t;
endpackage

// ### design/lnpc_link_regs.sv
/*
 * Node identity, PHY access control and isochronous cycle timer
 * registers of a 1394 link core, with a plain register port.
 * Assumes PHY-side event inputs come from logic on the same clock;
 * only the external cycle input is an asynchronous pin.
 */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "lnpc_regs.svh"

module lnpc_link_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire lnpc_pkg::lnpc_addr_t addr_i,
    input wire lnpc_pkg::lnpc_word_t wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output lnpc_pkg::lnpc_word_t rdata_o,
    // Bus reset and self-identification results
    input wire logic bus_reset_i,
    input wire logic phy_node_valid_i,
    input wire logic [5:0] phy_node_num_i,
    input wire logic phy_root_i,
    input wire logic cable_power_ok_i,
    input wire logic seg_update_i,
    input wire logic [9:0] seg_value_i,
    output logic [15:0] node_id_o,
    // PHY register request
    output logic phy_req_valid_o,
    output logic phy_req_write_o,
    output logic [3:0] phy_req_addr_o,
    output logic [7:0] phy_req_data_o,
    input wire logic phy_req_ready_i,
    // PHY register return
    input wire logic phy_ret_valid_i,
    input wire logic [3:0] phy_ret_addr_i,
    input wire logic [7:0] phy_ret_data_i,
    // Cycle start packets and external cycle pin
    input wire logic rx_cs_valid_i,
    input wire lnpc_pkg::lnpc_word_t rx_cs_data_i,
    output logic tx_cs_valid_o,
    output lnpc_pkg::lnpc_word_t tx_cs_data_o,
    input wire logic external_cycle_input_i
);
    import lnpc_pkg::*;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // One-hot select: node identity, PHY access, cycle time, link control.
    function automatic logic [3:0] reg_sel(input lnpc_addr_t a);
        logic [3:0] s;
        s = 4'h0;
        if (a == `LNPC_NODE_ID_OFF) begin
            s = 4'h1;
        end else if (a == `LNPC_PHY_CTL_OFF) begin
            s = 4'h2;
        end else if (a == `LNPC_CYC_TIME_OFF) begin
            s = 4'h4;
        end else if (a == `LNPC_LINK_CTL_OFF) begin
            s = 4'h8;
        end
        return s;
    endfunction

    lnpc_state_t st_q;
    lnpc_state_t st_d;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [19:0] acc_sum;
    logic clk_tick;
    logic ext_tick;
    logic cnt_tick;
    logic off_roll;
    logic cyc_roll;
    logic rx_load;
    logic phy_sent;
    logic [31:0] timer_next;

    assign wsel = we_i ? reg_sel(addr_i) : 4'h0;
    assign rsel = re_i ? reg_sel(addr_i) : 4'h0;

    // ----------------------------------------------------------------
    // Tick generation
    // ----------------------------------------------------------------
    // A phase accumulator spreads 24.576 MHz ticks over the 250 MHz
    // clock, so the long-term rate is exact while jitter is one cycle.
    assign acc_sum = {1'b0, st_q.acc} + {1'b0, `LNPC_TICK_KHZ};
    assign clk_tick = acc_sum >= {1'b0, `LNPC_CLK_KHZ};
    // The filtered pin changes only once the second and third stages agree.
    assign ext_tick = (st_q.sync2 == st_q.sync3) && st_q.sync3 && !st_q.ext_filt;
    assign cnt_tick = clk_tick && st_q.ten;
    assign off_roll = st_q.extsel ? ext_tick : (cnt_tick && st_q.off == `LNPC_OFF_LAST);
    assign cyc_roll = off_roll && st_q.cyc == `LNPC_CYC_LAST;
    assign rx_load = rx_cs_valid_i && !st_q.master;
    assign phy_sent = phy_req_valid_o && phy_req_ready_i;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        timer_next = 32'h0000_0000;
        st_d.sync1 = external_cycle_input_i;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        if (st_q.sync2 == st_q.sync3) begin
            st_d.ext_filt = st_q.sync3;
        end
        st_d.acc = clk_tick ? 19'(acc_sum - {1'b0, `LNPC_CLK_KHZ}) : acc_sum[18:0];

        // Node identity: the new node number wins over a bus reset.
        if (bus_reset_i) begin
            st_d.valid = 1'b0;
        end
        if (phy_node_valid_i) begin
            st_d.valid = 1'b1;
            st_d.node = phy_node_num_i;
            st_d.root = phy_root_i;
        end
        st_d.pwr_ok = cable_power_ok_i;
        if (seg_update_i) begin
            st_d.seg = seg_value_i;
        end
        if (wsel[0]) begin
            st_d.seg = wdata_i[`LNPC_SEG_FLD];
        end

        // PHY access control.
        if (phy_sent) begin
            if (phy_req_write_o) begin
                st_d.wrreq = 1'b0;
            end else begin
                st_d.rdreq = 1'b0;
            end
        end
        if (wsel[1]) begin
            st_d.rdreq = wdata_i[`LNPC_RDREQ_BIT];
            st_d.wrreq = wdata_i[`LNPC_WRREQ_BIT];
            st_d.taddr = wdata_i[`LNPC_TADDR_FLD];
            st_d.wval = wdata_i[`LNPC_WVAL_FLD];
            if (wdata_i[`LNPC_RDREQ_BIT] || wdata_i[`LNPC_WRREQ_BIT]) begin
                st_d.done = 1'b0;
            end
        end
        // A return in the same cycle as the clearing write still counts.
        if (phy_ret_valid_i) begin
            st_d.done = 1'b1;
            st_d.raddr = phy_ret_addr_i;
            st_d.rval = phy_ret_data_i;
        end

        // Cycle timer: counts while ten is set, or on pin ticks when extsel is set, unless a packet or software loads it.
        if (st_q.extsel && ext_tick) begin
            st_d.off = 12'h000;
        end else if (cnt_tick) begin
            st_d.off = (st_q.off == `LNPC_OFF_LAST && !st_q.extsel) ? 12'h000 : 12'(st_q.off + 12'h001);
        end
        if (off_roll) begin
            st_d.cyc = cyc_roll ? 13'h0000 : 13'(st_q.cyc + 13'h0001);
            if (cyc_roll) begin
                st_d.secs = 7'(st_q.secs + 7'h01);
            end
        end
        if (rx_load) begin
            st_d.secs = rx_cs_data_i[`LNPC_SECS_FLD];
            st_d.cyc = rx_cs_data_i[`LNPC_CYC_FLD];
            st_d.off = rx_cs_data_i[`LNPC_OFF_FLD];
        end
        if (wsel[2]) begin
            st_d.secs = wdata_i[`LNPC_SECS_FLD];
            st_d.cyc = wdata_i[`LNPC_CYC_FLD];
            st_d.off = wdata_i[`LNPC_OFF_FLD];
        end
        timer_next = {st_d.secs, st_d.cyc, st_d.off};
        st_d.tx_v = off_roll && st_q.master;
        if (off_roll && st_q.master) begin
            st_d.tx_data = timer_next;
        end

        if (wsel[3]) begin
            st_d.extsel = wdata_i[`LNPC_EXTSEL_BIT];
            st_d.master = wdata_i[`LNPC_MASTER_BIT];
            st_d.ten = wdata_i[`LNPC_TEN_BIT];
        end

        // Read data stands for exactly the cycle after the strobe.
        st_d.rdata = 32'h0000_0000;
        if (rsel[0]) begin
            st_d.rdata = {st_q.valid, st_q.root, 2'h0, st_q.pwr_ok, 11'h000, st_q.seg, st_q.node};
        end else if (rsel[1]) begin
            st_d.rdata = {st_q.done, 3'h0, st_q.raddr, st_q.rval, st_q.rdreq, st_q.wrreq, 2'h0,
                          st_q.taddr, st_q.wval};
        end else if (rsel[2]) begin
            st_d.rdata = {st_q.secs, st_q.cyc, st_q.off};
        end else if (rsel[3]) begin
            st_d.rdata = {9'h000, st_q.extsel, st_q.master, st_q.ten, 20'h00000};
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
            st_q.seg <= `LNPC_SEG_RST;
            st_q.node <= `LNPC_NODE_UNSET;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Read has priority if software breaks the one-request rule.
    assign phy_req_valid_o = st_q.rdreq || st_q.wrreq;
    assign phy_req_write_o = st_q.wrreq && !st_q.rdreq;
    assign phy_req_addr_o = st_q.taddr;
    assign phy_req_data_o = st_q.wval;
    assign rdata_o = st_q.rdata;
    assign node_id_o = {st_q.seg, st_q.node};
    assign tx_cs_valid_o = st_q.tx_v;
    assign tx_cs_data_o = st_q.tx_data;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic node_id_valid_flag_w;
    assign node_id_valid_flag_w = st_q.valid;
    property p_valid_clr;
        bus_reset_i && !phy_node_valid_i |=> !node_id_valid_flag_w;
    endproperty
    a_valid_clr: assert property (p_valid_clr) else $error("valid flag not cleared by bus reset");

    property p_node_load;
        phy_node_valid_i |=> st_q.valid && node_id_o[5:0] == $past(phy_node_num_i) && st_q.root == $past(phy_root_i);
    endproperty
    a_node_load: assert property (p_node_load) else $error("node number not loaded");

    property p_pwr_ok;
        ##1 st_q.pwr_ok == $past(cable_power_ok_i);
    endproperty
    a_pwr_ok: assert property (p_pwr_ok) else $error("cable power flag wrong");

    property p_nid_rsvd;
        re_i && addr_i == `LNPC_NODE_ID_OFF |=> rdata_o[29:28] == 2'h0 && rdata_o[26:16] == 11'h000;
    endproperty
    a_nid_rsvd: assert property (p_nid_rsvd) else $error("node reserved bits nonzero");

    property p_done_clr;
        wsel[1] && (wdata_i[`LNPC_RDREQ_BIT] || wdata_i[`LNPC_WRREQ_BIT]) && !phy_ret_valid_i |=> !st_q.done;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("read complete not cleared");

    property p_ret;
        phy_ret_valid_i |=> st_q.done && st_q.raddr == $past(phy_ret_addr_i) && st_q.rval == $past(phy_ret_data_i);
    endproperty
    a_ret: assert property (p_ret) else $error("PHY return not captured");

    property p_rd_clr;
        phy_sent && !phy_req_write_o && !wsel[1] |=> !st_q.rdreq;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read request not cleared");

    property p_wr_hold;
        st_q.wrreq && !phy_req_ready_i && !wsel[1] |=> st_q.wrreq;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request dropped early");

    property p_off_wrap;
        cnt_tick && !st_q.extsel && st_q.off == `LNPC_OFF_LAST && !rx_load && !wsel[2] |=> st_q.off == 12'h000;
    endproperty
    a_off_wrap: assert property (p_off_wrap) else $error("offset did not wrap at 3072");

    property p_hold;
        !st_q.ten && !(st_q.extsel && ext_tick) && !rx_load && !wsel[2] |=> $stable(st_q.off);
    endproperty
    a_hold: assert property (p_hold) else $error("offset moved while disabled");

    property p_tx;
        tx_cs_valid_o |-> $past(st_q.master) && tx_cs_data_o == {st_q.secs, st_q.cyc, st_q.off};
    endproperty
    a_tx: assert property (p_tx) else $error("cycle start payload wrong");

    // Software writes and received loads win over counting, so the timer checks leave them out.
    property p_nid_flags;
        rsel[0] |=> rdata_o[31:27] == {$past(st_q.valid), $past(st_q.root), 2'h0, $past(st_q.pwr_ok)};
    endproperty
    a_nid_flags: assert property (p_nid_flags) else $error("node flags read wrong");

    property p_seg_sw;
        wsel[0] |=> st_q.seg == $past(wdata_i[`LNPC_SEG_FLD]);
    endproperty
    a_seg_sw: assert property (p_seg_sw) else $error("bus segment write lost");

    property p_seg_hw;
        seg_update_i && !wsel[0] |=> st_q.seg == $past(seg_value_i);
    endproperty
    a_seg_hw: assert property (p_seg_hw) else $error("bus segment update lost");

    property p_nid_read;
        rsel[0] |=> rdata_o[15:0] == $past(node_id_o);
    endproperty
    a_nid_read: assert property (p_nid_read) else $error("node identifier read wrong");

    property p_node_keep;
        !phy_node_valid_i |=> $stable(st_q.node);
    endproperty
    a_node_keep: assert property (p_node_keep) else $error("node number changed without PHY");

    property p_rd_issue;
        wsel[1] && wdata_i[`LNPC_RDREQ_BIT] |=> phy_req_valid_o && !phy_req_write_o;
    endproperty
    a_rd_issue: assert property (p_rd_issue) else $error("read request not issued");

    property p_wr_issue;
        wsel[1] && wdata_i[`LNPC_WRREQ_BIT] && !wdata_i[`LNPC_RDREQ_BIT] |=> phy_req_valid_o && phy_req_write_o;
    endproperty
    a_wr_issue: assert property (p_wr_issue) else $error("write request not issued");

    property p_wr_clr;
        phy_sent && phy_req_write_o && !wsel[1] |=> !st_q.wrreq;
    endproperty
    a_wr_clr: assert property (p_wr_clr) else $error("write request not cleared");

    property p_req_fields;
        wsel[1] |=> phy_req_addr_o == $past(wdata_i[`LNPC_TADDR_FLD])
            && phy_req_data_o == $past(wdata_i[`LNPC_WVAL_FLD]);
    endproperty
    a_req_fields: assert property (p_req_fields) else $error("PHY target fields wrong");

    property p_phy_rsvd;
        rsel[1] |=> rdata_o[30:28] == 3'h0 && rdata_o[13:12] == 2'h0;
    endproperty
    a_phy_rsvd: assert property (p_phy_rsvd) else $error("PHY reserved bits nonzero");

    property p_rx_load;
        rx_load && !wsel[2] |=> {st_q.secs, st_q.cyc, st_q.off} == $past(rx_cs_data_i);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("received cycle start not loaded");

    property p_tx_gen;
        off_roll && st_q.master |=> tx_cs_valid_o;
    endproperty
    a_tx_gen: assert property (p_tx_gen) else $error("no cycle start on rollover");

    property p_tx_once;
        !(off_roll && st_q.master) |=> !tx_cs_valid_o;
    endproperty
    a_tx_once: assert property (p_tx_once) else $error("cycle start without rollover");

    property p_cyc_step;
        off_roll && !cyc_roll && !rx_load && !wsel[2] |=> st_q.cyc == 13'($past(st_q.cyc) + 13'h0001);
    endproperty
    a_cyc_step: assert property (p_cyc_step) else $error("cycle index did not advance");

    property p_sec_step;
        cyc_roll && !rx_load && !wsel[2] |=> st_q.cyc == 13'h0000 && st_q.secs == 7'($past(st_q.secs) + 7'h01);
    endproperty
    a_sec_step: assert property (p_sec_step) else $error("seconds did not advance");

    property p_off_step;
        cnt_tick && !st_q.extsel && st_q.off != `LNPC_OFF_LAST && !rx_load && !wsel[2]
            |=> st_q.off == 12'($past(st_q.off) + 12'h001);
    endproperty
    a_off_step: assert property (p_off_step) else $error("offset did not advance");

    property p_ext_zero;
        st_q.extsel && ext_tick && !rx_load && !wsel[2] |=> st_q.off == 12'h000;
    endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("offset not zeroed by external tick");

    property p_ext_roll;
        st_q.extsel && ext_tick && !cyc_roll && !rx_load && !wsel[2] |=> st_q.cyc == 13'($past(st_q.cyc) + 13'h0001);
    endproperty
    a_ext_roll: assert property (p_ext_roll) else $error("external tick did not roll over");

    c_phy_read: cover property (phy_sent && !phy_req_write_o ##[1:20] phy_ret_valid_i);
    c_tx_cs: cover property (tx_cs_valid_o);
    c_rx_load: cover property (rx_load);
    c_ext_tick: cover property (st_q.extsel && ext_tick);
    c_node_lost: cover property (st_q.valid ##1 !st_q.valid);
endmodule

// ### testbench/lnpc_phy_model.sv
/*
 * Behavioural PHY register file on the far side of the link registers.
 * Assumes the same clock as the link block; answers promptly or slowly.
 */
`timescale 1ns/1ps

module lnpc_phy_model (
    // Clock, reset and pacing
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic slow_i,
    // Request from the link
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [3:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    output logic req_ready_o,
    // Register transfer back to the link
    output logic ret_valid_o,
    output logic [3:0] ret_addr_o,
    output logic [7:0] ret_data_o
);
    logic [7:0] regs [16];
    logic [3:0] wait_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 8'h50 + 8'(i);
            end
            wait_q <= 4'h0;
            req_ready_o <= 1'b0;
            ret_valid_o <= 1'b0;
            ret_addr_o <= 4'h0;
            ret_data_o <= 8'h00;
        end else begin
            req_ready_o <= 1'b0;
            ret_valid_o <= 1'b0;
            // Released return lines toggle so that stale values never look valid.
            ret_addr_o <= ~ret_addr_o;
            ret_data_o <= ~ret_data_o;
            if (req_valid_i && !req_ready_o) begin
                if (wait_q == (slow_i ? 4'hA : 4'h0)) begin
                    req_ready_o <= 1'b1;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
            if (req_valid_i && req_ready_o) begin
                if (req_write_i) begin
                    regs[req_addr_i] <= req_data_i;
                end else begin
                    ret_valid_o <= 1'b1;
                    ret_addr_o <= req_addr_i;
                    ret_data_o <= regs[req_addr_i];
                end
            end
        end
    end
endmodule

// ### testbench/testbench.sv
/*
 * Self-checking bench for the link node, PHY access and cycle timer registers.
 * Assumes the PHY model beside it and a 250 MHz clock.
 */
`timescale 1ns/1ps

module testbench;
    import lnpc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    lnpc_addr_t addr_i = 8'h00;
    lnpc_word_t wdata_i = 32'h0, rx_cs_data_i = 32'h0, rdata_o, tx_cs_data_o;
    logic we_i = 0, re_i = 0, bus_reset_i = 0, phy_node_valid_i = 0, phy_root_i = 0;
    logic cable_power_ok_i = 0, seg_update_i = 0, rx_cs_valid_i = 0, external_cycle_input_i = 0, slow = 0;
    logic [5:0] phy_node_num_i = 6'h00;
    logic [9:0] seg_value_i = 10'h000;
    logic [15:0] node_id_o;
    logic phy_req_valid_o, phy_req_write_o, phy_req_ready_i, phy_ret_valid_i, tx_cs_valid_o;
    logic [3:0] phy_req_addr_o, phy_ret_addr_i;
    logic [7:0] phy_req_data_o, phy_ret_data_i;
    int num_errors = 0;
    int samples_checked = 0;
    int n;

    always #2 clk_i = ~clk_i;

    lnpc_link_regs lnpc_link_regs_i (.clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
        .bus_reset_i, .phy_node_valid_i, .phy_node_num_i, .phy_root_i, .cable_power_ok_i,
        .seg_update_i, .seg_value_i, .node_id_o, .phy_req_valid_o, .phy_req_write_o,
        .phy_req_addr_o, .phy_req_data_o, .phy_req_ready_i, .phy_ret_valid_i, .phy_ret_addr_i,
        .phy_ret_data_i, .rx_cs_valid_i, .rx_cs_data_i, .tx_cs_valid_o, .tx_cs_data_o,
        .external_cycle_input_i);

    lnpc_phy_model lnpc_phy_model_i (.clk_i, .rstn_i, .slow_i(slow), .req_valid_i(phy_req_valid_o),
        .req_write_i(phy_req_write_o), .req_addr_i(phy_req_addr_o), .req_data_i(phy_req_data_o),
        .req_ready_o(phy_req_ready_i), .ret_valid_o(phy_ret_valid_i), .ret_addr_o(phy_ret_addr_i),
        .ret_data_o(phy_ret_data_i));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input lnpc_word_t got, input lnpc_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input lnpc_addr_t a, input lnpc_word_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(input lnpc_addr_t a, input lnpc_word_t exp);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // A hang here is counted and ends the run.
    task automatic wait_phy();
        for (n = 0; n < 60 && (n == 0 || phy_req_valid_o); n++) begin
            @(posedge clk_i);
            #1;
        end
        if (n >= 60) begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic wait_tx();
        for (n = 1; n < 40000; n++) begin
            @(posedge clk_i);
            #1;
            if (tx_cs_valid_o) break;
        end
        if (n >= 40000) begin
            num_errors++;
            finish_test();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(8'hE8, 32'h0000_FFFF);
        rd(8'hEC, 32'h0000_0000);
        chk({16'h0, node_id_o}, 32'h0000_FFFF);
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_0000);
        $display("reset test done");
    endtask

    task automatic t_node();
        @(posedge clk_i);
        cable_power_ok_i <= 1'b1;
        phy_node_num_i <= 6'h05;
        phy_root_i <= 1'b1;
        phy_node_valid_i <= 1'b1;
        @(posedge clk_i);
        phy_node_valid_i <= 1'b0;
        rd(8'hE8, 32'hC800_FFC5);
        wr(8'hE8, 32'hFFFF_A940);
        rd(8'hE8, 32'hC800_A945);
        chk({16'h0, node_id_o}, 32'h0000_A945);
        @(posedge clk_i);
        bus_reset_i <= 1'b1;
        cable_power_ok_i <= 1'b0;
        @(posedge clk_i);
        bus_reset_i <= 1'b0;
        rd(8'hE8, 32'h4000_A945);
        @(posedge clk_i);
        seg_value_i <= 10'h155;
        seg_update_i <= 1'b1;
        @(posedge clk_i);
        seg_update_i <= 1'b0;
        phy_node_num_i <= 6'h3F;
        phy_root_i <= 1'b0;
        phy_node_valid_i <= 1'b1;
        @(posedge clk_i);
        phy_node_valid_i <= 1'b0;
        rd(8'hE8, 32'h8000_557F);
        $display("node test done");
    endtask

    task automatic t_phy();
        wr(8'hEC, 32'h0000_8300);
        wait_phy();
        rd(8'hEC, 32'h8353_0300);
        slow <= 1'b1;
        wr(8'hEC, 32'h0000_47A5);
        rd(8'hEC, 32'h0353_47A5);
        chk({27'h0, phy_req_valid_o, phy_req_write_o, phy_req_addr_o}, 32'h0000_0037);
        chk({24'h0, phy_req_data_o}, 32'h0000_00A5);
        wait_phy();
        rd(8'hEC, 32'h0353_07A5);
        slow <= 1'b0;
        wr(8'hEC, 32'h0000_8700);
        wait_phy();
        rd(8'hEC, 32'h87A5_0700);
        wr(8'hEC, 32'h7FFF_3512);
        rd(8'hEC, 32'h87A5_0512);
        $display("phy test done");
    endtask

    task automatic t_timer();
        wr(8'hF0, 32'hFFF3_FBFF);
        rd(8'hF0, 32'hFFF3_FBFF);
        wr(8'hF4, 32'h0030_0000);
        wait_tx();
        chk(tx_cs_data_o, 32'h0000_0000);
        @(posedge clk_i);
        #1;
        chk({31'h0, tx_cs_valid_o}, 32'h0);
        wait_tx();
        // 3072 ticks of 24.576 MHz is 31250 cycles of the core clock.
        chk(32'(n > 31240 && n < 31260), 32'h1);
        chk(tx_cs_data_o, 32'h0000_1000);
        wr(8'hF4, 32'h0000_0000);
        @(posedge clk_i);
        rx_cs_data_i <= 32'h2468_0ABC;
        rx_cs_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_cs_valid_i <= 1'b0;
        rd(8'hF0, 32'h2468_0ABC);
        wr(8'hF4, 32'h0060_0000);
        @(posedge clk_i);
        rx_cs_data_i <= 32'h1111_1111;
        rx_cs_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_cs_valid_i <= 1'b0;
        rd(8'hF0, 32'h2468_0ABC);
        @(posedge clk_i);
        external_cycle_input_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        external_cycle_input_i <= 1'b0;
        rd(8'hF0, 32'h2468_1000);
        chk(tx_cs_data_o, 32'h2468_1000);
        rd(8'hF4, 32'h0060_0000);
        $display("timer test done");
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_node();
        t_phy();
        t_timer();
        finish_test();
    end
endmodule
